/* File: rtl/rmp_map.vh */
`ifndef RMP_MAP_VH
`define RMP_MAP_VH
// Register byte offsets
`define RMP_A_PORT 8'h00
`define RMP_A_BAUD 8'h04
`define RMP_A_PARITY 8'h08
`define RMP_A_STOP 8'h0C
`define RMP_A_HSHAKE 8'h10
`define RMP_A_OPTION 8'h14
`define RMP_A_MODEM 8'h18
`define RMP_A_EOM 8'h1C
`define RMP_A_CMD 8'h20
`define RMP_A_STATUS 8'h24
`define RMP_A_TXDATA 8'h28
`define RMP_A_RXDATA 8'h2C
// Field codes
`define RMP_PAR_NONE 2'h0
`define RMP_PAR_ODD 2'h1
`define RMP_PAR_EVEN 2'h2
`define RMP_STOP_AUTO 2'h0
`define RMP_STOP_ONE 2'h1
`define RMP_HS_NONE 3'h0
`define RMP_HS_485 3'h4
`define RMP_HS_MODEM 3'h6
`define RMP_PORT_A 2'h1
`define RMP_PORT_B 2'h3
// Option word positions, bit 1 is the MSB
`define RMP_OPT_EARLY 5
`define RMP_OPT_EOM 4
`define RMP_OPT_MODEM 0
`define RMP_EOM_MAX 8'h64
// Baud rates
`define RMP_B300 16'd300
`define RMP_B600 16'd600
`define RMP_B1200 16'd1200
`define RMP_B2400 16'd2400
`define RMP_B4800 16'd4800
`define RMP_B9600 16'd9600
`define RMP_B19200 16'd19200
`define RMP_MS_PER_S 1000
`define RMP_DATA_BITS 4'h8
`define RMP_GAP_X2 7'h07
// Error codes
`define RMP_ERR_NONE 4'h0
`define RMP_ERR_PORT 4'h1
`define RMP_ERR_BAUD 4'h2
`define RMP_ERR_PAR 4'h3
`define RMP_ERR_STOP 4'h4
`define RMP_ERR_HS 4'h5
`define RMP_ERR_EOM 4'h6
// Command and status bits
`define RMP_CMD_OPEN 0
`define RMP_CMD_CLOSE 1
`define RMP_ST_ACTIVE 0
`define RMP_ST_TXBUSY 1
`define RMP_ST_FRAME 2
`define RMP_ST_RXERR 3
`define RMP_ST_RXVAL 4
`define RMP_ST_MODEM 5
`define RMP_RST_PORT 2'h1
`define RMP_RST_BAUD 16'd9600
`endif

/* File: rtl/rmp_port.v */
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`include "rmp_map.vh"
module rmp_port #(
  parameter CLK_HZ = 20000000
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rxd,
  input wire cts,
  output reg txd,
  output reg rts,
  output reg de,
  output reg modem_en
);
  localparam [31:0] MS_LAST = CLK_HZ / `RMP_MS_PER_S - 1;
  reg wr_ph_q;
  reg [7:0] ph_addr_q;
  reg [1:0] port_q;
  reg [15:0] baud_q;
  reg [1:0] par_q;
  reg [1:0] stop_q;
  reg [2:0] hs_q;
  reg [15:0] opt_q;
  reg [15:0] modem_q;
  reg [7:0] eom_q;
  reg active_q;
  reg [3:0] err_q;
  reg frame_q;
  reg rxerr_q;
  reg rxval_q;
  reg [7:0] rxbyte_q;
  reg [7:0] txbyte_q;
  reg txpend_q;
  wire acc = hsel & hready & htrans[1];
  wire wr = wr_ph_q;
  wire par_on = par_q != `RMP_PAR_NONE;
  // Two stops only for no parity with automatic selection
  wire [1:0] nstop = (stop_q == `RMP_STOP_AUTO && !par_on) ? 2'h2 : 2'h1;
  wire [3:0] cbits = 4'h1 + `RMP_DATA_BITS + {3'h0, par_on} + {2'h0, nstop};
  // 3.5 characters in bit times, rounded up
  wire [6:0] gap_bits = (({3'h0, cbits} * `RMP_GAP_X2) + 7'h01) >> 1;
  wire user_eom = opt_q[`RMP_OPT_EOM];
  wire early_ok = opt_q[`RMP_OPT_EARLY];
  reg [31:0] bdiv_w;
  always @* begin
    case (baud_q)
      `RMP_B300: bdiv_w = CLK_HZ / `RMP_B300;
      `RMP_B600: bdiv_w = CLK_HZ / `RMP_B600;
      `RMP_B1200: bdiv_w = CLK_HZ / `RMP_B1200;
      `RMP_B2400: bdiv_w = CLK_HZ / `RMP_B2400;
      `RMP_B4800: bdiv_w = CLK_HZ / `RMP_B4800;
      `RMP_B9600: bdiv_w = CLK_HZ / `RMP_B9600;
      `RMP_B19200: bdiv_w = CLK_HZ / `RMP_B19200;
      default: bdiv_w = 32'h0;
    endcase
  end
  wire [16:0] bdiv = bdiv_w[16:0];
  // Connection check on open command
  reg [3:0] chk_err;
  always @* begin
    chk_err = `RMP_ERR_NONE;
    if (port_q != `RMP_PORT_A && port_q != `RMP_PORT_B)
      chk_err = `RMP_ERR_PORT;
    else if (bdiv == 17'h0)
      chk_err = `RMP_ERR_BAUD;
    else if (par_q > `RMP_PAR_EVEN)
      chk_err = `RMP_ERR_PAR;
    else if (stop_q > `RMP_STOP_ONE)
      chk_err = `RMP_ERR_STOP;
    else if (hs_q != `RMP_HS_NONE && hs_q != `RMP_HS_485 && hs_q != `RMP_HS_MODEM)
      chk_err = `RMP_ERR_HS;
    // Interval field consulted only with option 12 set
    else if (user_eom && (eom_q == 8'h0 || eom_q > `RMP_EOM_MAX))
      chk_err = `RMP_ERR_EOM;
  end
  // Free running bit and millisecond ticks
  reg [16:0] bt_q;
  reg [31:0] ms_q;
  wire btick = active_q && (bt_q == bdiv - 17'h1);
  wire mtick = active_q && (ms_q == MS_LAST);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bt_q <= 17'h0;
      ms_q <= 32'h0;
    end else begin
      bt_q <= (btick || !active_q) ? 17'h0 : bt_q + 17'h1;
      ms_q <= (mtick || !active_q) ? 32'h0 : ms_q + 32'h1;
    end
  end
  // Transmitter
  reg tx_busy_q;
  reg [16:0] tx_div_q;
  reg [3:0] tx_idx_q;
  reg [11:0] tx_sh_q;
  reg [6:0] guard_q;
  wire tx_par = (par_q == `RMP_PAR_ODD) ? ~^txbyte_q : ^txbyte_q;
  wire cts_ok = (hs_q != `RMP_HS_MODEM) || cts;
  wire tx_go = active_q && txpend_q && !tx_busy_q && cts_ok;
  wire tx_end = tx_busy_q && tx_div_q == 17'h0 && tx_idx_q == cbits - 4'h1;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy_q <= 1'b0;
      tx_div_q <= 17'h0;
      tx_idx_q <= 4'h0;
      tx_sh_q <= 12'hFFF;
      txd <= 1'b1;
      rts <= 1'b0;
      de <= 1'b0;
      guard_q <= 7'h0;
    end else begin
      // Standard character timing always, interval never applies here
      if (tx_go) begin
        tx_busy_q <= 1'b1;
        tx_div_q <= bdiv - 17'h1;
        tx_idx_q <= 4'h0;
        tx_sh_q <= {2'h3, par_on ? tx_par : 1'b1, txbyte_q, 1'b0};
        txd <= 1'b0;
      end else if (tx_end) begin
        tx_busy_q <= 1'b0;
        txd <= 1'b1;
      end else if (tx_busy_q) begin
        if (tx_div_q == 17'h0) begin
          tx_div_q <= bdiv - 17'h1;
          tx_idx_q <= tx_idx_q + 4'h1;
          tx_sh_q <= {1'b1, tx_sh_q[11:1]};
          txd <= tx_sh_q[1];
        end else begin
          tx_div_q <= tx_div_q - 17'h1;
        end
      end
      rts <= active_q && hs_q == `RMP_HS_MODEM && (txpend_q || tx_busy_q);
      de <= active_q && hs_q == `RMP_HS_485 && (tx_go || (tx_busy_q && !tx_end));
      // Reply guard of 3.5 characters after our own transmission
      if (tx_busy_q)
        guard_q <= gap_bits;
      else if (btick && guard_q != 7'h0)
        guard_q <= guard_q - 7'h1;
    end
  end
  // Receiver
  reg rx_busy_q;
  reg rx_skip_q;
  reg [16:0] rx_div_q;
  reg [3:0] rx_idx_q;
  reg [7:0] rx_sh_q;
  reg rx_par_q;
  reg fopen_q;
  reg fbad_q;
  reg [7:0] gap_q;
  wire [3:0] stop_idx = `RMP_DATA_BITS + 4'h1 + {3'h0, par_on};
  wire rx_smp = rx_busy_q && rx_div_q == 17'h0;
  wire rx_start = active_q && !rx_busy_q && !rxd;
  wire rx_done = rx_smp && rx_idx_q == stop_idx;
  wire par_bad = par_on && ((par_q == `RMP_PAR_ODD) ? ~(^{rx_sh_q, rx_par_q}) : ^{rx_sh_q, rx_par_q});
  wire byte_bad = !rxd || par_bad;
  // Standard gap counts bit times, user gap counts milliseconds
  wire gap_tick = user_eom ? mtick : btick;
  wire [7:0] gap_lim = user_eom ? eom_q : {1'b0, gap_bits};
  wire gap_end = fopen_q && !rx_busy_q && gap_q >= gap_lim;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_busy_q <= 1'b0;
      rx_skip_q <= 1'b0;
      rx_div_q <= 17'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 8'h0;
      rx_par_q <= 1'b0;
      fopen_q <= 1'b0;
      fbad_q <= 1'b0;
      gap_q <= 8'h0;
    end else begin
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        // Early replies dropped unless option 11 set
        rx_skip_q <= guard_q != 7'h0 && !early_ok;
        rx_div_q <= {1'b0, bdiv[16:1]};
        rx_idx_q <= 4'h0;
      end else if (rx_smp) begin
        rx_div_q <= bdiv - 17'h1;
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && rxd)
          rx_busy_q <= 1'b0;
        else if (rx_idx_q <= `RMP_DATA_BITS && rx_idx_q != 4'h0)
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
        else if (rx_idx_q == `RMP_DATA_BITS + 4'h1 && par_on)
          rx_par_q <= rxd;
        if (rx_done)
          rx_busy_q <= 1'b0;
      end else if (rx_busy_q) begin
        rx_div_q <= rx_div_q - 17'h1;
      end
      if (rx_done && !rx_skip_q) begin
        fopen_q <= 1'b1;
        fbad_q <= fbad_q || byte_bad;
      end else if (gap_end) begin
        fopen_q <= 1'b0;
        fbad_q <= 1'b0;
      end
      if (rx_busy_q || rx_start)
        gap_q <= 8'h0;
      else if (gap_tick && gap_q != 8'hFF)
        gap_q <= gap_q + 8'h1;
    end
  end
  wire rx_take = rx_done && !rx_skip_q && !byte_bad;
  wire frame_set = gap_end && !fbad_q;
  wire rxerr_set = gap_end && fbad_q;
  // Bus slave and register file
  reg [31:0] rd_mux;
  always @* begin
    case (haddr[7:0])
      `RMP_A_PORT: rd_mux = {30'h0, port_q};
      `RMP_A_BAUD: rd_mux = {16'h0, baud_q};
      `RMP_A_PARITY: rd_mux = {30'h0, par_q};
      `RMP_A_STOP: rd_mux = {30'h0, stop_q};
      `RMP_A_HSHAKE: rd_mux = {29'h0, hs_q};
      `RMP_A_OPTION: rd_mux = {16'h0, opt_q};
      `RMP_A_MODEM: rd_mux = {16'h0, modem_q};
      `RMP_A_EOM: rd_mux = {24'h0, eom_q};
      `RMP_A_STATUS: rd_mux = {16'h0, 2'h0, nstop, err_q, 2'h0, modem_en, rxval_q,
                              rxerr_q, frame_q, txpend_q | tx_busy_q, active_q};
      `RMP_A_TXDATA: rd_mux = {24'h0, txbyte_q};
      `RMP_A_RXDATA: rd_mux = {24'h0, rxbyte_q};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_rx = acc && !hwrite && haddr[7:0] == `RMP_A_RXDATA;
  wire wsel_st = wr && ph_addr_q == `RMP_A_STATUS;
  wire wsel_cmd = wr && ph_addr_q == `RMP_A_CMD;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      ph_addr_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      port_q <= `RMP_RST_PORT;
      baud_q <= `RMP_RST_BAUD;
      par_q <= `RMP_PAR_NONE;
      stop_q <= `RMP_STOP_AUTO;
      hs_q <= `RMP_HS_NONE;
      opt_q <= 16'h0;
      modem_q <= 16'h0;
      eom_q <= 8'h0;
      active_q <= 1'b0;
      err_q <= `RMP_ERR_NONE;
      frame_q <= 1'b0;
      rxerr_q <= 1'b0;
      rxval_q <= 1'b0;
      rxbyte_q <= 8'h0;
      txbyte_q <= 8'h0;
      txpend_q <= 1'b0;
      modem_en <= 1'b0;
    end else begin
      wr_ph_q <= acc && hwrite;
      if (acc) begin
        ph_addr_q <= haddr[7:0];
        if (!hwrite)
          hrdata <= rd_mux;
      end
      // Configuration frozen while a connection is open
      if (wr && !active_q) begin
        case (ph_addr_q)
          `RMP_A_PORT: port_q <= hwdata[1:0];
          `RMP_A_BAUD: baud_q <= hwdata[15:0];
          `RMP_A_PARITY: par_q <= hwdata[1:0];
          `RMP_A_STOP: stop_q <= hwdata[1:0];
          `RMP_A_HSHAKE: hs_q <= hwdata[2:0];
          `RMP_A_OPTION: opt_q <= hwdata[15:0];
          `RMP_A_MODEM: modem_q <= hwdata[15:0];
          `RMP_A_EOM: eom_q <= hwdata[7:0];
          default: ;
        endcase
      end
      if (wsel_cmd && hwdata[`RMP_CMD_CLOSE]) begin
        active_q <= 1'b0;
      end else if (wsel_cmd && hwdata[`RMP_CMD_OPEN] && !active_q) begin
        err_q <= chk_err;
        active_q <= chk_err == `RMP_ERR_NONE;
      end
      modem_en <= active_q && opt_q[`RMP_OPT_MODEM];
      // Set wins over a write-one clear
      frame_q <= frame_set | (frame_q & ~(wsel_st & hwdata[`RMP_ST_FRAME]));
      rxerr_q <= rxerr_set | (rxerr_q & ~(wsel_st & hwdata[`RMP_ST_RXERR]));
      rxval_q <= rx_take | (rxval_q & ~rd_rx);
      if (rx_take)
        rxbyte_q <= rx_sh_q;
      if (wr && ph_addr_q == `RMP_A_TXDATA && active_q && !txpend_q) begin
        txbyte_q <= hwdata[7:0];
        txpend_q <= 1'b1;
      end else if (tx_go || !active_q) begin
        txpend_q <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/rmp_port_monitor.sv */
`timescale 1ns/100ps
module rmp_port_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire cts,
  input wire txd,
  input wire rts,
  input wire de,
  input wire modem_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_start;
    $fell(txd);
  endsequence
  sequence s_low8;
    !txd [*8];
  endsequence
  a_bus_okay: assert property (!hresp) else $error("bad resp");
  a_ready_high: assert property (hreadyout) else $error("wait state");
  a_read_hold: assert property ($changed(hrdata) |->
    $past(hsel && htrans[1] && !hwrite && hready)) else $error("rdata moved");
  a_reset_idle: assert property ($rose(hresetn) |->
    txd && !rts && !de && !modem_en) else $error("not idle");
  a_cts_hold: assert property (rts && !cts |-> txd) else $error("sent early");
  a_rts_tail: assert property ($fell(rts) |-> txd && $past(txd)) else $error("rts");
  a_de_tail: assert property ($fell(de) |-> txd && $past(txd)) else $error("de");
  a_mode_excl: assert property (!(rts && de)) else $error("rts and de");
  a_start_len: assert property (s_start |-> s_low8) else $error("short start");
endmodule
bind rmp_port rmp_port_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cts(cts), .txd(txd), .rts(rts), .de(de),
  .modem_en(modem_en));

/* File: testbench/rmp_slave.sv */
`timescale 1ns/100ps
module rmp_slave #(
  parameter T = 104,
  parameter DLY = 40
) (
  input wire hclk,
  input wire txd,
  input wire rts,
  output reg rxd,
  output reg cts
);
  reg [7:0] got;
  integer k;
  integer j;
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    k = 0;
  end
  // Slow modem: clear to send lags the request
  always @(posedge hclk) begin
    k <= rts ? k + 1 : 0;
    cts <= rts && (k >= DLY);
  end
  // Mid-bit sampling at standard bit timing
  always begin
    @(negedge txd);
    repeat (T / 2) @(posedge hclk);
    for (j = 0; j < 8; j = j + 1) begin
      repeat (T) @(posedge hclk);
      got[j] = txd;
    end
  end
  task send(input [7:0] b, input bad);
    integer i;
    reg [10:0] f;
    begin
      f = {1'b1, ^b ^ bad, b, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        rxd <= f[i];
        repeat (T) @(posedge hclk);
      end
    end
  endtask
endmodule

/* File: testbench/rtu_master_port_framing_test.sv */
`timescale 1ns/100ps
`include "rmp_map.vh"
module rtu_master_port_framing_test;
  localparam integer T = 2000000 / 19200;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rxd, cts, txd, rts, de, modem_en;
  integer err_count = 0;
  integer comparisons = 0;
  integer i;
  integer n;
  reg [31:0] r;
  always #25 hclk = ~hclk;
  rmp_port #(.CLK_HZ(2000000)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
    .cts(cts), .txd(txd), .rts(rts), .de(de), .modem_en(modem_en));
  rmp_slave #(.T(T), .DLY(40)) slv (.hclk(hclk), .txd(txd), .rts(rts), .rxd(rxd),
    .cts(cts));
  task wrap_up;
    begin
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task bail;
    begin
      err_count = err_count + 1;
      $display("ERROR %0t timeout", $time);
      wrap_up;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task near(input integer g, input integer e);
    chk((g < e - 4 || g > e + 4) ? g : e, e);
  endtask
  task hw;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
        @(posedge hclk);
        k = k + 1;
        if (k > 20) bail;
      end
    end
  endtask
  task xfer(input [7:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hw;
      htrans <= 2'h0;
      hwdata <= d;
      hw;
      r = hrdata;
    end
  endtask
  task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(r & m, e);
    end
  endtask
  // Closes first: the port ignores setup while open
  task cfg(input [31:0] p, b, pa, s, h, o, e);
    begin
      xfer(`RMP_A_CMD, 1'b1, 32'h2);
      xfer(`RMP_A_PORT, 1'b1, p);
      xfer(`RMP_A_BAUD, 1'b1, b);
      xfer(`RMP_A_PARITY, 1'b1, pa);
      xfer(`RMP_A_STOP, 1'b1, s);
      xfer(`RMP_A_HSHAKE, 1'b1, h);
      xfer(`RMP_A_OPTION, 1'b1, o);
      xfer(`RMP_A_EOM, 1'b1, e);
      xfer(`RMP_A_CMD, 1'b1, 32'h1);
      // Modem enable flop follows active by one cycle
      @(posedge hclk);
    end
  endtask
  task wsig(input integer s, input v);
    begin
      n = 0;
      while ((s == 0 ? txd : s == 1 ? rts : de) !== v) begin
        @(posedge hclk);
        n = n + 1;
        if (n > 3000) bail;
      end
    end
  endtask
  task poll(input [31:0] m);
    integer k;
    begin
      k = 0;
      r = 0;
      while ((r & m) == 0) begin
        xfer(`RMP_A_STATUS, 1'b0, 32'h0);
        k = k + 1;
        if (k > 3000) bail;
      end
      chk(r & m, m);
    end
  endtask
  initial begin
    repeat (100000) @(posedge hclk);
    bail;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({txd, rts, de, modem_en, hresp, hreadyout}, 6'h21);
    rdm(`RMP_A_PORT, 32'hFFFFFFFF, {30'h0, `RMP_RST_PORT});
    rdm(`RMP_A_BAUD, 32'hFFFFFFFF, {16'h0, `RMP_RST_BAUD});
    rdm(8'h40, 32'hFFFFFFFF, 32'h0);
    for (i = 1; i < 7; i = i + 1) begin
      cfg(i == 1 ? 2 : 1, i == 2 ? 1234 : 9600, i == 3 ? 3 : 0, i == 4 ? 2 : 0,
        i == 5 ? 5 : 0, i == 6 ? 32'h10 : 0, 0);
      rdm(`RMP_A_STATUS, 32'hF01, i << 8);
    end
    cfg(3, 19200, 0, 0, 6, 32'h1, 200);
    rdm(`RMP_A_STATUS, 32'h3F21, 32'h2021);
    chk(modem_en, 1'b1);
    xfer(`RMP_A_TXDATA, 1'b1, 32'hA5);
    wsig(0, 0);
    wsig(1, 0);
    near(n, 11 * T);
    chk(slv.got, 8'hA5);
    cfg(1, 19200, 0, 1, 0, 0, 0);
    rdm(`RMP_A_STATUS, 32'h3F21, 32'h1001);
    cfg(1, 19200, 2, 0, 4, 32'h20, 0);
    rdm(`RMP_A_STATUS, 32'h3F21, 32'h1001);
    xfer(`RMP_A_TXDATA, 1'b1, 32'h3C);
    wsig(2, 1);
    wsig(2, 0);
    near(n, 11 * T);
    chk(slv.got, 8'h3C);
    slv.send(8'h5A, 1'b0);
    rdm(`RMP_A_STATUS, 32'h10, 32'h10);
    rdm(`RMP_A_RXDATA, 32'hFF, 32'h5A);
    poll(32'h4);
    xfer(`RMP_A_STATUS, 1'b1, 32'hC);
    rdm(`RMP_A_STATUS, 32'hC, 32'h0);
    slv.send(8'h5A, 1'b1);
    poll(32'h8);
    rdm(`RMP_A_STATUS, 32'h4, 32'h0);
    xfer(`RMP_A_RXDATA, 1'b0, 32'h0);
    cfg(1, 19200, 2, 0, 4, 0, 0);
    xfer(`RMP_A_TXDATA, 1'b1, 32'h3C);
    wsig(2, 1);
    wsig(2, 0);
    slv.send(8'h5A, 1'b0);
    rdm(`RMP_A_STATUS, 32'h10, 32'h0);
    // User end gap of 5 ms outlasts the standard 3.5 character gap
    cfg(1, 19200, 2, 0, 4, 32'h30, 5);
    rdm(`RMP_A_STATUS, 32'hF01, 32'h1);
    slv.send(8'h5A, 1'b0);
    repeat (6000) @(posedge hclk);
    rdm(`RMP_A_STATUS, 32'h14, 32'h10);
    poll(32'h4);
    wrap_up;
  end
endmodule
